// *** verilog/pdmc_defs.svh ***
// Constants for the microphone capture block
// Function
// [R01] Block makes the microphone bit clock, takes one or two channels on one data line.
// [R02] Output is 16-bit PCM at 16 kHz.
// [R03] Bit clock to sample rate ratio is selectable as 64 or 80.
// [R04] Default: left bits on falling edge, right bits on rising edge.
// [R05] Edge swap setting exchanges which edge feeds left and right.
// [R06] Each channel has its own decimation filter down to 16-bit PCM.
// [R07] Stereo writes alternating left and right samples; mono writes left only.
// [R08] Words are little endian: left or earlier sample low half, other high.
// [R09] Stop finishes the current frame, then raises stopped.
// [R10] Stopped is raised only once all memory writes are done.
// [R11] Controller must not restart before stopped is seen.
// [R12] Each channel has a volume stage spanning -20 dB to +20 dB.
// [R13] Volume codes step by 0.5 dB.
// [R14] Buffer length counts 16-bit samples; bytes written equal twice length.
// [R15] Controller writes pointer and length before start.
// [R16] First samples after start may be invalid; discard about 50.
// [R17] Buffer pointer is double-buffered once started is raised.
// [R18] Full buffer raises end, switches to latched pointer, raises started.
// [R19] Controller keeps the buffer pointer inside data memory.
// [R20] Bit clock is divided from the system clock without added jitter.
// [R21] End is also raised when the last sample after stop is written.
// [R22] Start and stop are one-cycle pulses; events stay set until cleared.
`ifndef PDMC_DEFS_SVH
`define PDMC_DEFS_SVH
`define PDMC_RATIO_64        7'h40
`define PDMC_RATIO_80        7'h50
`define PDMC_SAMPLE_BITS     16
`define PDMC_GAIN_DEFAULT    7'h28
`define PDMC_GAIN_MIN        7'h00
`define PDMC_GAIN_MAX        7'h50
`define PDMC_GAIN_Q          4'hA
`define PDMC_CLKDIV_DEFAULT  8'h04
`define PDMC_CIC_W           32
`define PDMC_CIC_MID_80      32'h0003_E800
`define PDMC_CIC_MID_64      32'h0002_0000
`endif

// *** verilog/pdmc_pkg.sv ***
// Types for the microphone capture block
package pdmc_pkg;
   typedef enum logic {PDMC_STEREO, PDMC_MONO} pdmc_op_e;
   typedef enum logic [1:0] {PDMC_IDLE, PDMC_RUN, PDMC_DRAIN} pdmc_state_e;
   typedef logic [6:0] pdmc_gain_t;
endpackage

// *** verilog/pdmc_gain.sv ***
// Per-channel volume stage, 0.5 dB per code
`include "pdmc_defs.svh"
module pdmc_gain (
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   input  wire logic                  in_valid,
   input  wire logic signed [15:0]    in_sample,
   input  wire pdmc_pkg::pdmc_gain_t  volume,
   output logic signed [15:0]         out_sample
);
   import pdmc_pkg::*;
   // Multipliers for 0..+20 dB in 0.5 dB steps, Q10 (1024 = 0 dB)
   function automatic logic [13:0] mul_of(input logic [5:0] s);
      logic [13:0] t [0:40];
      t = '{14'h0400, 14'h043D, 14'h047D, 14'h04C1, 14'h0509, 14'h0556, 14'h05A6,
            14'h05FC, 14'h0657, 14'h06B7, 14'h071D, 14'h0789, 14'h07FB, 14'h0874,
            14'h08F4, 14'h097C, 14'h0A0C, 14'h0AA5, 14'h0B46, 14'h0BF1, 14'h0CA6,
            14'h0D66, 14'h0E31, 14'h0F09, 14'h0FED, 14'h10DE, 14'h11DE, 14'h12ED,
            14'h140C, 14'h153C, 14'h167E, 14'h17D4, 14'h193D, 14'h1ABC, 14'h1C51,
            14'h1DFF, 14'h1FC6, 14'h21A8, 14'h23A6, 14'h25C3, 14'h2800};
      mul_of = t[s];
   endfunction
   wire pdmc_gain_t  vol_sat  = (volume > `PDMC_GAIN_MAX) ? `PDMC_GAIN_MAX : volume; // R12
   wire              atten    = vol_sat < `PDMC_GAIN_DEFAULT;
   wire [5:0]        step     = atten ? 6'(`PDMC_GAIN_DEFAULT - vol_sat)
                                      : 6'(vol_sat - `PDMC_GAIN_DEFAULT); // R13
   wire [13:0]       mul      = mul_of(step);
   wire signed [31:0] prod    = 32'(in_sample) * $signed({18'h00000, mul});
   wire signed [31:0] quot    = atten ? 32'((48'(in_sample) <<< 10) / $signed({34'h0, mul}))
                                      : (prod >>> `PDMC_GAIN_Q);
   wire signed [15:0] sat     = (quot > 32'sh7FFF) ? 16'sh7FFF :
                                (quot < -32'sh8000) ? 16'sh8000 : quot[15:0];
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         out_sample <= 16'h0000;
      end else if (ce && in_valid) begin
         out_sample <= sat; // R12
      end
   end
endmodule

// *** verilog/pdmc_core.sv ***
// Microphone capture top: bit clock, channel split, decimation, packing, buffer writer
`include "pdmc_defs.svh"
module pdmc_core #(
   parameter int AW = 32,
   parameter int LW = 15
) (
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   input  wire logic                  bit_clock_link,
   input  wire logic                  task_start,
   input  wire logic                  task_stop,
   input  wire logic                  clear_started,
   input  wire logic                  clear_stopped,
   input  wire logic                  clear_end,
   input  wire logic                  enable,
   input  wire logic [7:0]            bit_clock_frequency_control,
   input  wire pdmc_pkg::pdmc_op_e    operation,
   input  wire logic                  edge_swap,
   input  wire logic                  ratio_80,
   input  wire pdmc_pkg::pdmc_gain_t  left_volume,
   input  wire pdmc_pkg::pdmc_gain_t  right_volume,
   input  wire logic [AW-1:0]         buffer_pointer,
   input  wire logic [LW-1:0]         buffer_length,
   input  wire logic                  pdm_data,
   output logic                       microphone_bit_clock,
   output logic                       event_started,
   output logic                       event_stopped,
   output logic                       event_end,
   output logic                       busy,
   output logic                       mem_valid,
   output logic [AW-1:0]              mem_addr,
   output logic [31:0]                mem_data,
   input  wire logic                  mem_ready
);
   import pdmc_pkg::*;
   // ---------------------------------------------------------------
   // Bit clock divider
   // ---------------------------------------------------------------
   logic [7:0] div_reg;
   logic       run_clk_reg;
   wire  [7:0] half_div = (bit_clock_frequency_control == 8'h00) ? 8'h01
                                                                 : bit_clock_frequency_control;
   wire        div_wrap = (div_reg >= half_div - 8'h01);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_reg <= 8'h00;
         microphone_bit_clock <= 1'b0;
      end else if (ce) begin
         div_reg <= (div_wrap || !run_clk_reg) ? 8'h00 : div_reg + 8'h01;
         if (!run_clk_reg) microphone_bit_clock <= 1'b0;
         else if (div_wrap) microphone_bit_clock <= ~microphone_bit_clock; // R20 R01
      end
   end
   // ---------------------------------------------------------------
   // Link domain: capture on each edge of the returned bit clock
   // ---------------------------------------------------------------
   logic rise_bit_reg;
   logic fall_bit_reg;
   logic rise_tog_reg;
   always_ff @(posedge bit_clock_link or negedge resetn) begin
      if (!resetn) begin
         rise_bit_reg <= 1'b0;
         rise_tog_reg <= 1'b0;
      end else begin
         rise_bit_reg <= pdm_data;
         rise_tog_reg <= ~rise_tog_reg;
      end
   end
   always_ff @(negedge bit_clock_link or negedge resetn) begin
      if (!resetn) begin
         fall_bit_reg <= 1'b0;
      end else begin
         fall_bit_reg <= pdm_data;
      end
   end
   // ---------------------------------------------------------------
   // Crossing: toggle marks a full bit pair, data held stable meanwhile
   // ---------------------------------------------------------------
   logic [2:0] tog_sync_reg;
   logic [1:0] rise_sync_reg;
   logic [1:0] fall_sync_reg;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tog_sync_reg  <= 3'h0;
         rise_sync_reg <= 2'h0;
         fall_sync_reg <= 2'h0;
      end else if (ce) begin
         tog_sync_reg  <= {tog_sync_reg[1:0], rise_tog_reg};
         rise_sync_reg <= {rise_sync_reg[0], rise_bit_reg};
         fall_sync_reg <= {fall_sync_reg[0], fall_bit_reg};
      end
   end
   wire pair_stb  = tog_sync_reg[2] ^ tog_sync_reg[1];
   wire left_bit  = edge_swap ? rise_sync_reg[1] : fall_sync_reg[1]; // R04 R05
   wire right_bit = edge_swap ? fall_sync_reg[1] : rise_sync_reg[1]; // R04 R05
   // ---------------------------------------------------------------
   // Decimation: CIC3 per channel, ratio 64 or 80
   // ---------------------------------------------------------------
   localparam int CW = `PDMC_CIC_W;
   logic [6:0]           dec_cnt_reg;
   logic                 active_reg;
   wire  [6:0]           ratio   = ratio_80 ? `PDMC_RATIO_80 : `PDMC_RATIO_64; // R03
   wire                  dec_stb = pair_stb && active_reg && (dec_cnt_reg == ratio - 7'h01);
   logic signed [15:0]   gout [2];
   logic                 pcm_valid_reg;
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         logic [CW-1:0] i1_reg, i2_reg, i3_reg, c1_reg, c2_reg, c3_reg;
         logic signed [15:0] pcm_reg;
         wire [CW-1:0] bitv = (ch == 0 ? left_bit : right_bit) ? CW'(1) : CW'(0);
         wire [CW-1:0] d1 = i3_reg - c1_reg;
         wire [CW-1:0] d2 = d1 - c2_reg;
         wire [CW-1:0] d3 = d2 - c3_reg;
         // Full scale 80^3 maps to 16 bits; 64^3 scaled alike
         wire [CW-1:0] cen = d3 - (ratio_80 ? CW'(`PDMC_CIC_MID_80) : CW'(`PDMC_CIC_MID_64));
         wire [CW-1:0] scl = ratio_80 ? CW'($signed(cen) >>> 3) : CW'($signed(cen) >>> 2);
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               {i1_reg, i2_reg, i3_reg} <= '0;
               {c1_reg, c2_reg, c3_reg} <= '0;
               pcm_reg <= 16'h0000;
            end else if (ce && pair_stb) begin
               i1_reg <= i1_reg + bitv;
               i2_reg <= i2_reg + i1_reg;
               i3_reg <= i3_reg + i2_reg;
               if (dec_stb) begin
                  c1_reg  <= i3_reg;
                  c2_reg  <= d1;
                  c3_reg  <= d2;
                  pcm_reg <= ($signed(scl) > 32'sh7FFF) ? 16'sh7FFF :
                             ($signed(scl) < -32'sh8000) ? 16'sh8000 : scl[15:0]; // R06 R02
               end
            end
         end
         pdmc_gain u_gain (
            .mclk       (mclk),
            .resetn     (resetn),
            .ce         (ce),
            .in_valid   (pcm_valid_reg),
            .in_sample  (pcm_reg),
            .volume     (ch == 0 ? left_volume : right_volume),
            .out_sample (gout[ch])
         ); // R12 R13
      end
   endgenerate
   logic gain_valid_reg;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dec_cnt_reg    <= 7'h00;
         pcm_valid_reg  <= 1'b0;
         gain_valid_reg <= 1'b0;
      end else if (ce) begin
         pcm_valid_reg  <= dec_stb;
         gain_valid_reg <= pcm_valid_reg;
         if (!active_reg) dec_cnt_reg <= 7'h00;
         else if (pair_stb) dec_cnt_reg <= (dec_cnt_reg >= ratio - 7'h01) ? 7'h00
                                                                          : dec_cnt_reg + 7'h01;
      end
   end
   // ---------------------------------------------------------------
   // Control, packing and buffer writer
   // ---------------------------------------------------------------
   pdmc_state_e  state_reg;
   logic [AW-1:0] base_reg;
   logic [LW-1:0] cnt_reg;
   logic         half_reg;
   logic [15:0]  low_reg;
   logic         stop_req_reg;
   wire          mem_done   = mem_valid && mem_ready;
   wire          mono       = (operation == PDMC_MONO);
   wire          word_ready = gain_valid_reg && (state_reg == PDMC_RUN) && !mem_valid
                              && (!mono || half_reg);
   wire [31:0]   word       = mono ? {gout[0], low_reg} : {gout[1], gout[0]}; // R08 R07
   wire [LW-1:0] cnt_after  = cnt_reg + LW'(2); // R14
   wire          buf_full   = mem_done && (cnt_after >= buffer_length);
   wire          stop_now   = mem_done && (stop_req_reg || task_stop);
   wire          swap_buf   = buf_full && !stop_now;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg    <= PDMC_IDLE;
         active_reg   <= 1'b0;
         run_clk_reg  <= 1'b0;
         base_reg     <= '0;
         cnt_reg      <= '0;
         half_reg     <= 1'b0;
         low_reg      <= 16'h0000;
         stop_req_reg <= 1'b0;
         mem_valid    <= 1'b0;
         mem_addr     <= '0;
         mem_data     <= 32'h0000_0000;
      end else if (ce) begin
         if (mono && gain_valid_reg && state_reg == PDMC_RUN && !half_reg) begin
            low_reg  <= gout[0];
            half_reg <= 1'b1;
         end else if (word_ready) begin
            half_reg <= 1'b0;
         end
         if (word_ready) begin
            mem_valid <= 1'b1;
            mem_data  <= word;
            mem_addr  <= base_reg + AW'({cnt_reg, 1'b0});
         end else if (mem_done) begin
            mem_valid <= 1'b0;
         end
         if (mem_done) cnt_reg <= swap_buf ? '0 : cnt_after;
         if (swap_buf) base_reg <= buffer_pointer; // R18 R17
         unique case (state_reg)
            PDMC_IDLE: if (task_start && enable) begin // R22
               state_reg    <= PDMC_RUN;
               active_reg   <= 1'b1;
               run_clk_reg  <= 1'b1;
               base_reg     <= buffer_pointer; // R15
               cnt_reg      <= '0;
               half_reg     <= 1'b0;
               stop_req_reg <= 1'b0;
            end
            PDMC_RUN: begin
               if (task_stop) stop_req_reg <= 1'b1; // R09
               if (stop_now) begin
                  state_reg <= PDMC_DRAIN;
                  active_reg <= 1'b0;
               end
            end
            PDMC_DRAIN: if (!mem_valid) begin // R10
               state_reg   <= PDMC_IDLE;
               run_clk_reg <= 1'b0;
            end
         endcase
      end
   end
   assign busy = (state_reg != PDMC_IDLE);
   // ---------------------------------------------------------------
   // Sticky events, set wins over clear
   // ---------------------------------------------------------------
   wire set_started = ce && ((state_reg == PDMC_IDLE && task_start && enable) || swap_buf);
   wire set_end     = ce && (buf_full || stop_now); // R18 R21
   wire set_stopped = ce && state_reg == PDMC_DRAIN && !mem_valid; // R09 R10
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         event_started <= 1'b0;
         event_stopped <= 1'b0;
         event_end     <= 1'b0;
      end else if (ce) begin
         event_started <= set_started | (event_started & ~clear_started); // R22
         event_stopped <= set_stopped | (event_stopped & ~clear_stopped); // R22
         event_end     <= set_end     | (event_end     & ~clear_end); // R22
      end
   end
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_stop_after_drain: assert property (@(posedge mclk) disable iff (!resetn) // R10
      $rose(event_stopped) |-> !mem_valid && state_reg == PDMC_IDLE)
      else $error("stopped raised with write pending");
   chk_end_sticky: assert property (@(posedge mclk) disable iff (!resetn) // R21
      set_end |=> event_end)
      else $error("end event not set");
   chk_swap_started: assert property (@(posedge mclk) disable iff (!resetn) // R18
      swap_buf && ce |=> event_started && base_reg == $past(buffer_pointer))
      else $error("buffer swap without started");
   chk_ratio_count: assert property (@(posedge mclk) disable iff (!resetn) // R03
      dec_cnt_reg < (ratio_80 ? `PDMC_RATIO_80 : `PDMC_RATIO_64))
      else $error("decimation count out of range");
   chk_mono_pack: assert property (@(posedge mclk) disable iff (!resetn) // R08
      ce && word_ready && mono |=> mem_data[15:0] == $past(low_reg))
      else $error("mono packing wrong");
   chk_stereo_pack: assert property (@(posedge mclk) disable iff (!resetn) // R07
      ce && word_ready && !mono |=> mem_data == {$past(gout[1]), $past(gout[0])})
      else $error("stereo packing wrong");
   chk_addr_step: assert property (@(posedge mclk) disable iff (!resetn) // R14
      ce && word_ready |=> mem_addr == $past(base_reg) + AW'({$past(cnt_reg), 1'b0}))
      else $error("write address wrong");
   chk_idle_clock: assert property (@(posedge mclk) disable iff (!resetn) // R20
      !run_clk_reg && ce |=> !microphone_bit_clock)
      else $error("bit clock runs while idle");
   chk_sticky_started: assert property (@(posedge mclk) disable iff (!resetn) // R22
      event_started && !clear_started |=> event_started)
      else $error("started event lost");
   chk_sticky_stopped: assert property (@(posedge mclk) disable iff (!resetn) // R22
      event_stopped && !clear_stopped |=> event_stopped)
      else $error("stopped event lost");
   chk_sticky_end: assert property (@(posedge mclk) disable iff (!resetn) // R22
      event_end && !clear_end |=> event_end)
      else $error("end event lost");
   chk_idle_no_write: assert property (@(posedge mclk) disable iff (!resetn) // R10
      state_reg == PDMC_IDLE |-> !mem_valid)
      else $error("write pending while idle");
   chk_drain_short: assert property (@(posedge mclk) disable iff (!resetn) // R10
      ce && state_reg == PDMC_DRAIN |=> state_reg == PDMC_IDLE)
      else $error("drain does not finish");
   chk_stop_ends: assert property (@(posedge mclk) disable iff (!resetn) // R09 R21
      ce && stop_now |=> event_end && state_reg == PDMC_DRAIN)
      else $error("stop without end event");
   chk_start_taken: assert property (@(posedge mclk) disable iff (!resetn) // R22
      ce && state_reg == PDMC_IDLE && task_start && enable |=> busy && event_started)
      else $error("start pulse not taken");
   chk_mono_high: assert property (@(posedge mclk) disable iff (!resetn) // R08
      ce && word_ready && mono |=> mem_data[31:16] == $past(gout[0]))
      else $error("mono upper half wrong");
   chk_word_hold: assert property (@(posedge mclk) disable iff (!resetn) // R10
      mem_valid && !mem_ready |=> mem_valid && $stable(mem_data) && $stable(mem_addr))
      else $error("write request not held");
endmodule

// *** test/pdmc_mic_model.sv ***
// Pair of PDM microphones, left and right, sharing one data line
module pdmc_mic_model (
   input  wire logic bit_clock,
   output logic      data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase = 2'h0;
   initial data = 1'h0;
   always @(posedge bit_clock) begin
      phase <= phase + 2'h1;
   end
   // Left mic drives while clock high (75% ones), right while low (25% ones)
   always @(bit_clock) begin
      #20;
      data = bit_clock ? (phase != 2'h3) : (phase == 2'h3);
   end
endmodule

// *** test/pdmc_core_test.sv ***
// Self-checking bench for the microphone capture block
`include "pdmc_defs.svh"
module pdmc_core_test;
   timeunit 1ns;
   timeprecision 1ns;
   import pdmc_pkg::*;
   localparam logic [31:0] PTR_A = 32'h2000_0000;
   localparam logic [31:0] PTR_B = 32'h2000_0100;
   logic        mclk = 1'h0, resetn = 1'h0, enable = 1'h1;
   logic        task_start = 1'h0, task_stop = 1'h0, clear_started = 1'h0;
   logic        clear_stopped = 1'h0, clear_end = 1'h0, edge_swap = 1'h0;
   logic        ratio_80 = 1'h1, mem_ready = 1'h0;
   logic [7:0]  hp = 8'h04;
   pdmc_op_e    operation = PDMC_STEREO;
   pdmc_gain_t  left_volume = `PDMC_GAIN_DEFAULT, right_volume = `PDMC_GAIN_DEFAULT;
   logic [31:0] buffer_pointer = PTR_A;
   logic [14:0] buffer_length = 15'h0008;
   logic        microphone_bit_clock, pdm_data, event_started, event_stopped;
   logic        event_end, busy, mem_valid;
   logic [31:0] mem_addr, mem_data;
   int          n_errors = 0, n_compared = 0, cyc = 0, delay = 2, cnt = 0;
   logic [31:0] q_addr[$], q_data[$];
   int          q_cyc[$];

   pdmc_core u_pdmc_core (.mclk(mclk), .resetn(resetn), .ce(1'h1),
      .bit_clock_link(microphone_bit_clock), .task_start(task_start),
      .task_stop(task_stop), .clear_started(clear_started),
      .clear_stopped(clear_stopped), .clear_end(clear_end), .enable(enable),
      .bit_clock_frequency_control(hp), .operation(operation), .edge_swap(edge_swap),
      .ratio_80(ratio_80), .left_volume(left_volume), .right_volume(right_volume),
      .buffer_pointer(buffer_pointer), .buffer_length(buffer_length),
      .pdm_data(pdm_data), .microphone_bit_clock(microphone_bit_clock),
      .event_started(event_started), .event_stopped(event_stopped),
      .event_end(event_end), .busy(busy), .mem_valid(mem_valid),
      .mem_addr(mem_addr), .mem_data(mem_data), .mem_ready(mem_ready));
   pdmc_mic_model u_pdmc_mic_model (.bit_clock(microphone_bit_clock), .data(pdm_data));

   always #50 mclk = ~mclk;

   // ---------------------------------------------
   // Memory side: slow or prompt single-cycle ready
   // ---------------------------------------------
   always @(negedge mclk) begin
      cnt = (mem_valid && !mem_ready) ? cnt + 1 : 0;
      mem_ready <= mem_valid && !mem_ready && cnt > delay;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (mem_valid === 1'h1 && mem_ready === 1'h1) begin
         q_addr.push_back(mem_addr);
         q_data.push_back(mem_data);
         q_cyc.push_back(cyc);
      end
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
      n_compared++;
      if (seen !== exp_v) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp_v);
      end
   endtask
   task automatic pulse(ref logic sig);
      @(negedge mclk) sig = 1'h1;
      @(negedge mclk) sig = 1'h0;
   endtask
   task automatic wait_words(input int n);
      int t;
      t = 0;
      while (q_addr.size() < n && t < 60000) begin
         @(negedge mclk);
         t++;
      end
      check(q_addr.size() >= n, 32'h1);
   endtask
   // Words of one run: addresses, spacing, sign of both halves late in the run
   task automatic check_run(input logic [31:0] base, input int last, input int gap,
                            input logic lo_pos, input logic hi_pos);
      for (int k = 0; k < last; k++) begin
         check(q_addr[k], ((k < 4) ? base : PTR_B) + 32'(4 * (k % 4)));
         if (k >= 20) check(32'(q_cyc[k] - q_cyc[k - 1]), 32'(gap));
         if (k >= last - 8) begin
            check(q_data[k][15], !lo_pos);
            check(q_data[k][31], !hi_pos);
         end
      end
   endtask
   task automatic results();
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      int t, sz, r0, r1;
      repeat (16) @(negedge mclk);
      resetn = 1'h1;
      check({microphone_bit_clock, event_started, event_stopped, event_end, busy,
             mem_valid}, 32'h0);
      pulse(task_start);
      @(negedge mclk);
      check(event_started, 32'h1);
      check(busy, 32'h1);
      buffer_pointer = PTR_B;
      pulse(clear_started);
      wait_words(4);
      repeat (4) @(negedge mclk);
      check(event_end, 32'h1);
      check(event_started, 32'h1);
      pulse(clear_end);
      pulse(clear_started);
      wait_words(46);
      right_volume = `PDMC_GAIN_MIN;
      wait_words(58);
      check_run(PTR_A, 58, 640, 1'h1, 1'h0);
      r0 = -int'($signed(q_data[45][31:16]));
      r1 = -int'($signed(q_data[57][31:16]));
      check(r1 * 10 > r0 - 20 && r1 * 10 < r0 + 20, 32'h1);
      delay = 6;
      pulse(clear_end);
      sz = q_addr.size();
      pulse(task_stop);
      t = 0;
      while (busy !== 1'h0 && t < 3000) begin
         @(negedge mclk);
         t++;
      end
      check({event_stopped, event_end, mem_valid}, 32'h6);
      check(q_addr.size(), 32'(sz + 1));
      sz = q_addr.size();
      repeat (50) @(negedge mclk);
      check(q_addr.size(), 32'(sz));
      check(microphone_bit_clock, 32'h0);
      pulse(clear_stopped);
      pulse(clear_end);
      operation = PDMC_MONO;
      edge_swap = 1'h1;
      ratio_80 = 1'h0;
      delay = 0;
      q_addr.delete();
      q_data.delete();
      q_cyc.delete();
      pulse(task_start);
      wait_words(36);
      check_run(PTR_B, 36, 1024, 1'h0, 1'h0);
      results();
   end

   initial begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      results();
   end
endmodule
